// ---- design/rtctw_pkg.sv ----
// Shared constants and types of the two-wire clock/RAM slave link.
// Assumes a 250 MHz system clock on the bus-master end.
package rtctw_pkg;
    localparam logic [6:0] SLAVE_ADDR   = 7'h68;
    localparam logic       DIR_WRITE    = 1'b0;
    localparam logic       DIR_READ     = 1'b1;
    localparam int         BYTE_W       = 8;
    localparam int         REG_COUNT    = 64;
    localparam int         TIME_REGS    = 8;
    localparam int         PTR_W        = 6;
    localparam logic [3:0] BIT_ACK      = 4'h8;
    localparam logic [3:0] BIT_DONE     = 4'h9;
    localparam int         SYS_CLK_HZ   = 250_000_000;
    localparam int         SCL_MAX_HZ   = 100_000;
    // Rounded up so the bit rate never exceeds the limit
    localparam int         SCL_QTR_CYC  = (SYS_CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
    localparam int         QTR_W        = 10;
    localparam int         OP_W         = 2;
    localparam int         REQ_W        = OP_W + PTR_W + BYTE_W;

    typedef enum logic [OP_W-1:0] {OP_SNAP, OP_WRITE, OP_READ} rtctw_op_t;
    typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} rtctw_cmd_t;
endpackage

// ---- design/rtctw_if.sv ----
// Two-wire link between the bus master end and the clock/RAM slave end.
// Both lines are open-drain with pull-ups; the level is the AND of all drivers.
`timescale 1ns/1ps
`default_nettype none
interface rtctw_if;
    logic scl_out;
    logic scl_oe_n;
    logic sda_m_out;
    logic sda_m_oe_n;
    logic sda_s_out;
    logic sda_s_oe_n;
    logic scl;
    logic sda;

    assign scl = scl_oe_n ? 1'b1 : scl_out;
    assign sda = (sda_m_oe_n ? 1'b1 : sda_m_out) & (sda_s_oe_n ? 1'b1 : sda_s_out);

    modport host (output scl_out, scl_oe_n, sda_m_out, sda_m_oe_n, input scl, sda);
    modport dev  (output sda_s_out, sda_s_oe_n, input scl, sda);
endinterface
`default_nettype wire

// ---- design/rtctw_xfer.sv ----
// Toggle handshake carrying one request word from domain A to domain B
// and one answer word back. One request in flight; A must wait for busy low.
`timescale 1ns/1ps
`default_nettype none
module rtctw_xfer #(
    parameter int REQ_W = 16,
    parameter int RSP_W = 8
) (
    input  wire logic             a_clk_in,
    input  wire logic             a_srst_in,
    input  wire logic             a_req_in,
    input  wire logic [REQ_W-1:0] a_req_word_in,
    output logic                  a_busy_out,
    output logic                  a_rsp_valid_out,
    output logic      [RSP_W-1:0] a_rsp_word_out,
    input  wire logic             b_clk_in,
    input  wire logic             b_srst_in,
    output logic                  b_req_out,
    output logic      [REQ_W-1:0] b_req_word_out,
    input  wire logic [RSP_W-1:0] b_rsp_word_in
);
    if (REQ_W < 1 || RSP_W < 1) $error("rtctw_xfer: widths must be positive");

    typedef struct packed {
        logic             req_t;
        logic [REQ_W-1:0] word;
        logic             busy;
        logic             ack_m;
        logic             ack_s;
        logic             ack_p;
        logic             rsp_valid;
        logic [RSP_W-1:0] rsp;
    } rtctw_xa_t;

    typedef struct packed {
        logic             req_m;
        logic             req_s;
        logic             req_p;
        logic             pend;
        logic             ack_t;
        logic [RSP_W-1:0] rsp;
    } rtctw_xb_t;

    rtctw_xa_t a_q, a_d;
    rtctw_xb_t b_q, b_d;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        a_d           = a_q;
        a_d.rsp_valid = 1'b0;
        a_d.ack_m     = b_q.ack_t;
        a_d.ack_s     = a_q.ack_m;
        a_d.ack_p     = a_q.ack_s;
        if (a_q.ack_s != a_q.ack_p) begin
            // B holds its answer until the next request, so it is stable here
            a_d.busy      = 1'b0;
            a_d.rsp       = b_q.rsp;
            a_d.rsp_valid = 1'b1;
        end else if (a_req_in && !a_q.busy) begin
            a_d.req_t = ~a_q.req_t;
            a_d.word  = a_req_word_in;
            a_d.busy  = 1'b1;
        end
    end

    always_ff @(posedge a_clk_in) begin
        if (a_srst_in) begin
            a_q <= '0;
        end else begin
            a_q <= a_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        b_d       = b_q;
        b_d.req_m = a_q.req_t;
        b_d.req_s = b_q.req_m;
        b_d.req_p = b_q.req_s;
        b_d.pend  = b_q.req_s != b_q.req_p;
        if (b_q.pend) begin
            b_d.rsp   = b_rsp_word_in;
            b_d.ack_t = ~b_q.ack_t;
        end
    end

    always_ff @(posedge b_clk_in) begin
        if (b_srst_in) begin
            b_q <= '0;
        end else begin
            b_q <= b_d;
        end
    end

    assign a_busy_out      = a_q.busy;
    assign a_rsp_valid_out = a_q.rsp_valid;
    assign a_rsp_word_out  = a_q.rsp;
    assign b_req_out       = b_q.req_s != b_q.req_p;
    assign b_req_word_out  = a_q.word;
endmodule
`default_nettype wire

// ---- design/rtctw_dev.sv ----
// Slave end: two-wire clock/RAM interface with register store and time shadow.
// Link logic runs on LINK_CLK_IN and oversamples SCL/SDA; the store runs on
// CLK_IN. TIME_IN comes from timekeeping logic on CLK_IN.
//
// What this block does
// - Answer only address 1101000 plus direction bit
// - First byte after START is the address
// - Address decoded by hardware after full byte
// - Direction zero means master writes to us
// - Acknowledge matching address in ninth clock
// - START begins, STOP ends every transfer
// - Acknowledge every byte received in writes
// - First written byte loads register pointer
// - Any number of data bytes stored, acknowledged
// - Master ends writes with STOP
// - Direction one means we drive data
// - Read starts at current register pointer
// - Without pointer write, previous pointer is used
// - Master not-acknowledge ends our data drive
// - Master sets pointer, then starts read
// - Every byte travels most significant bit first
// - Master clocks at 100 kHz at most
// - Master acknowledges all read bytes but last
// - START copies running time into shadow
`timescale 1ns/1ps
`default_nettype none
module rtctw_dev
    import rtctw_pkg::*;
#(
    parameter int REG_COUNT = rtctw_pkg::REG_COUNT,
    parameter int TIME_REGS = rtctw_pkg::TIME_REGS
) (
    input  wire logic                                 CLK_IN,
    input  wire logic                                 SRST_IN,
    input  wire logic                                 LINK_CLK_IN,
    input  wire logic                                 LINK_SRST_IN,
    rtctw_if.dev                                      BUS,
    input  wire logic [TIME_REGS*rtctw_pkg::BYTE_W-1:0] TIME_IN,
    output logic                                      WR_STB_OUT,
    output logic      [rtctw_pkg::PTR_W-1:0]          WR_ADDR_OUT,
    output logic      [rtctw_pkg::BYTE_W-1:0]         WR_DATA_OUT
);
    import rtctw_pkg::*;

    if (REG_COUNT != 2 ** PTR_W || TIME_REGS < 1 || TIME_REGS > REG_COUNT)
        $error("rtctw_dev: register count must fill the pointer range");

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_TX} rtctw_st_t;

    typedef struct packed {
        logic              scl_m;
        logic              scl_s;
        logic              scl_p;
        logic              sda_m;
        logic              sda_s;
        logic              sda_p;
        rtctw_st_t         st;
        logic [3:0]        cnt;
        logic [BYTE_W-1:0] sh;
        logic [BYTE_W-1:0] tx;
        logic              rw;
        logic [PTR_W-1:0]  ptr;
        logic              oe_n;
        logic              req;
        logic [REQ_W-1:0]  req_word;
    } rtctw_link_t;

    typedef struct packed {
        logic [REG_COUNT-1:0][BYTE_W-1:0] mem;
        logic [TIME_REGS-1:0][BYTE_W-1:0] shadow;
        logic [BYTE_W-1:0]                rsp;
        logic                             wr_stb;
        logic [PTR_W-1:0]                 wr_addr;
        logic [BYTE_W-1:0]                wr_data;
    } rtctw_sys_t;

    function automatic logic [REQ_W-1:0] mk_req(input rtctw_op_t op,
                                                input logic [PTR_W-1:0] addr,
                                                input logic [BYTE_W-1:0] data);
        mk_req = {op, addr, data};
    endfunction

    rtctw_link_t       l_q, l_d;
    rtctw_sys_t        s_q, s_d;
    logic              rise, fall, start, stop;
    logic              x_busy;
    logic              x_rsp_valid;
    logic [BYTE_W-1:0] x_rsp;
    logic              b_req;
    logic [REQ_W-1:0]  b_word;
    rtctw_op_t         b_op;
    logic [PTR_W-1:0]  b_addr;
    logic [BYTE_W-1:0] b_data;

    ////////////////////////////////////////////////////////////////////////////
    // Link side
    assign rise  = l_q.scl_s && !l_q.scl_p;
    assign fall  = !l_q.scl_s && l_q.scl_p;
    assign start = l_q.scl_s && l_q.scl_p && l_q.sda_p && !l_q.sda_s;
    assign stop  = l_q.scl_s && l_q.scl_p && !l_q.sda_p && l_q.sda_s;

    always_comb begin
        l_d       = l_q;
        l_d.scl_m = BUS.scl;
        l_d.scl_s = l_q.scl_m;
        l_d.scl_p = l_q.scl_s;
        l_d.sda_m = BUS.sda;
        l_d.sda_s = l_q.sda_m;
        l_d.sda_p = l_q.sda_s;
        l_d.req   = 1'b0;
        if (start) begin
            // Repeated START also lands here and restarts framing
            l_d.st       = ST_ADDR;
            l_d.cnt      = 4'h0;
            l_d.oe_n     = 1'b1;
            l_d.req      = 1'b1;
            l_d.req_word = mk_req(OP_SNAP, l_q.ptr, 8'h00);
        end else if (stop) begin
            l_d.st   = ST_IDLE;
            l_d.oe_n = 1'b1;
        end else if (l_q.st != ST_IDLE && rise) begin
            if (l_q.cnt < BIT_ACK) begin
                l_d.sh  = {l_q.sh[BYTE_W-2:0], l_q.sda_s};
                l_d.cnt = l_q.cnt + 4'h1;
            end else if (l_q.st == ST_TX && l_q.sda_s) begin
                l_d.st   = ST_IDLE;
                l_d.oe_n = 1'b1;
            end
        end else if (l_q.st != ST_IDLE && fall) begin
            if (l_q.cnt == BIT_ACK) begin
                l_d.cnt  = BIT_DONE;
                l_d.oe_n = 1'b0;
                unique case (l_q.st)
                    ST_ADDR: begin
                        if (l_q.sh[BYTE_W-1:1] == SLAVE_ADDR) begin
                            l_d.rw = l_q.sh[0];
                            if (l_q.sh[0] == DIR_READ) begin
                                l_d.req      = 1'b1;
                                l_d.req_word = mk_req(OP_READ, l_q.ptr, 8'h00);
                            end
                        end else begin
                            l_d.st   = ST_IDLE;
                            l_d.oe_n = 1'b1;
                        end
                    end
                    ST_PTR: begin
                        l_d.ptr = l_q.sh[PTR_W-1:0];
                    end
                    ST_WDATA: begin
                        l_d.req      = 1'b1;
                        l_d.req_word = mk_req(OP_WRITE, l_q.ptr, l_q.sh);
                        l_d.ptr      = l_q.ptr + 1'b1;
                    end
                    ST_TX: begin
                        // Release for the master's acknowledge, fetch the next byte
                        l_d.oe_n     = 1'b1;
                        l_d.ptr      = l_q.ptr + 1'b1;
                        l_d.req      = 1'b1;
                        l_d.req_word = mk_req(OP_READ, l_q.ptr + 1'b1, 8'h00);
                    end
                    default: begin
                        l_d.oe_n = 1'b1;
                    end
                endcase
            end else if (l_q.cnt == BIT_DONE) begin
                l_d.cnt  = 4'h0;
                l_d.oe_n = 1'b1;
                unique case (l_q.st)
                    ST_ADDR: begin
                        if (l_q.rw == DIR_READ) begin
                            l_d.st   = ST_TX;
                            l_d.tx   = x_rsp;
                            l_d.oe_n = x_rsp[BYTE_W-1];
                        end else begin
                            l_d.st = ST_PTR;
                        end
                    end
                    ST_PTR: begin
                        l_d.st = ST_WDATA;
                    end
                    ST_TX: begin
                        l_d.tx   = x_rsp;
                        l_d.oe_n = x_rsp[BYTE_W-1];
                    end
                    default: begin
                    end
                endcase
            end else if (l_q.st == ST_TX && l_q.cnt != 4'h0) begin
                l_d.tx   = {l_q.tx[BYTE_W-2:0], 1'b0};
                l_d.oe_n = l_q.tx[BYTE_W-2];
            end
        end
    end

    always_ff @(posedge LINK_CLK_IN) begin
        if (LINK_SRST_IN) begin
            l_q      <= '0;
            l_q.oe_n <= 1'b1;
        end else begin
            l_q <= l_d;
        end
    end

    assign BUS.sda_s_out  = 1'b0;
    assign BUS.sda_s_oe_n = l_q.oe_n;

    ////////////////////////////////////////////////////////////////////////////
    // Crossing: bytes are far apart at 100 kHz, so one request in flight suffices
    rtctw_xfer #(
        .REQ_W (REQ_W),
        .RSP_W (BYTE_W)
    ) u_xfer (
        .a_clk_in        (LINK_CLK_IN),
        .a_srst_in       (LINK_SRST_IN),
        .a_req_in        (l_q.req),
        .a_req_word_in   (l_q.req_word),
        .a_busy_out      (x_busy),
        .a_rsp_valid_out (x_rsp_valid),
        .a_rsp_word_out  (x_rsp),
        .b_clk_in        (CLK_IN),
        .b_srst_in       (SRST_IN),
        .b_req_out       (b_req),
        .b_req_word_out  (b_word),
        .b_rsp_word_in   (s_q.rsp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register store side
    assign b_op   = rtctw_op_t'(b_word[REQ_W-1 -: OP_W]);
    assign b_addr = b_word[BYTE_W +: PTR_W];
    assign b_data = b_word[BYTE_W-1:0];

    always_comb begin
        s_d        = s_q;
        s_d.wr_stb = 1'b0;
        if (b_req) begin
            unique case (b_op)
                OP_SNAP: begin
                    for (int i = 0; i < TIME_REGS; i++) begin
                        s_d.shadow[i] = TIME_IN[i*BYTE_W +: BYTE_W];
                    end
                end
                OP_WRITE: begin
                    s_d.mem[b_addr] = b_data;
                    s_d.wr_stb      = 1'b1;
                    s_d.wr_addr     = b_addr;
                    s_d.wr_data     = b_data;
                end
                OP_READ: begin
                    // Time bytes come from the frozen copy, not the live counters
                    s_d.rsp = (b_addr < TIME_REGS) ? s_q.shadow[b_addr] : s_q.mem[b_addr];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign WR_STB_OUT  = s_q.wr_stb;
    assign WR_ADDR_OUT = s_q.wr_addr;
    assign WR_DATA_OUT = s_q.wr_data;
endmodule
`default_nettype wire

// ---- design/rtctw_host.sv ----
// Bus master end: byte-level commands START, WRITE, READ, STOP.
// SCL is divided from CLK_IN; no clock stretching by the slave is expected.
`timescale 1ns/1ps
`default_nettype none
module rtctw_host
    import rtctw_pkg::*;
#(
    parameter int QTR_CYC = rtctw_pkg::SCL_QTR_CYC
) (
    input  wire logic                         CLK_IN,
    input  wire logic                         SRST_IN,
    rtctw_if.host                             BUS,
    input  wire logic                         CMD_VALID_IN,
    output logic                              CMD_READY_OUT,
    input  wire rtctw_pkg::rtctw_cmd_t        CMD_IN,
    input  wire logic [rtctw_pkg::BYTE_W-1:0] CMD_DATA_IN,
    input  wire logic                         CMD_LAST_IN,
    output logic                              RSP_VALID_OUT,
    output logic      [rtctw_pkg::BYTE_W-1:0] RSP_DATA_OUT,
    output logic                              RSP_ACK_OUT
);
    import rtctw_pkg::*;

    if (QTR_CYC < 1 || QTR_CYC >= 2 ** QTR_W) $error("rtctw_host: bad QTR_CYC");

    typedef enum logic [1:0] {M_IDLE, M_START, M_BITS, M_STOP} rtctw_mst_t;

    typedef struct packed {
        logic            sda_m;
        logic            sda_s;
        rtctw_mst_t      st;
        logic [QTR_W-1:0] div;
        logic [1:0]      qtr;
        logic [3:0]      bitn;
        logic [BYTE_W:0] tx;
        logic [BYTE_W:0] rx;
        logic            scl_oe_n;
        logic            sda_oe_n;
        logic            rsp_valid;
        logic [BYTE_W-1:0] rsp_data;
        logic            rsp_ack;
    } rtctw_host_t;

    // Line levels per quarter: {scl_oe_n, sda_oe_n}
    function automatic logic [1:0] pins(input rtctw_mst_t st, input logic [1:0] q,
                                        input logic b);
        unique case (st)
            M_START: pins = (q == 2'h0) ? 2'h1 : (q == 2'h1) ? 2'h3 : (q == 2'h2) ? 2'h2 : 2'h0;
            M_BITS:  pins = {(q == 2'h1 || q == 2'h2), b};
            M_STOP:  pins = (q == 2'h0) ? 2'h0 : (q == 2'h1) ? 2'h2 : 2'h3;
            default: pins = 2'h3;
        endcase
    endfunction

    localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);

    rtctw_host_t q_q, q_d;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        q_d           = q_q;
        q_d.sda_m     = BUS.sda;
        q_d.sda_s     = q_q.sda_m;
        q_d.rsp_valid = 1'b0;
        if (q_q.st == M_IDLE) begin
            if (CMD_VALID_IN) begin
                q_d.div  = '0;
                q_d.qtr  = 2'h0;
                q_d.bitn = 4'h0;
                unique case (CMD_IN)
                    CMD_START: begin
                        q_d.st = M_START;
                        q_d.tx = {CMD_DATA_IN, 1'b1};
                    end
                    CMD_WRITE: begin
                        q_d.st = M_BITS;
                        q_d.tx = {CMD_DATA_IN, 1'b1};
                    end
                    CMD_READ: begin
                        q_d.st = M_BITS;
                        q_d.tx = {8'hFF, CMD_LAST_IN};
                    end
                    CMD_STOP: begin
                        q_d.st = M_STOP;
                    end
                endcase
                {q_d.scl_oe_n, q_d.sda_oe_n} = pins(q_d.st, 2'h0, q_d.tx[BYTE_W]);
            end
        end else if (q_q.div != QTR_LAST) begin
            q_d.div = q_q.div + 1'b1;
        end else begin
            q_d.div = '0;
            q_d.qtr = q_q.qtr + 2'h1;
            if (q_q.st == M_BITS && q_q.qtr == 2'h2) begin
                q_d.rx = {q_q.rx[BYTE_W-1:0], q_q.sda_s};
            end
            if (q_q.qtr == 2'h3) begin
                unique case (q_q.st)
                    M_START: begin
                        q_d.st = M_BITS;
                    end
                    M_BITS: begin
                        q_d.tx   = {q_q.tx[BYTE_W-1:0], 1'b1};
                        q_d.bitn = q_q.bitn + 4'h1;
                        if (q_q.bitn == BIT_ACK) begin
                            q_d.st        = M_IDLE;
                            q_d.rsp_valid = 1'b1;
                            q_d.rsp_data  = q_q.rx[BYTE_W:1];
                            q_d.rsp_ack   = !q_q.rx[0];
                        end
                    end
                    default: begin
                        q_d.st = M_IDLE;
                    end
                endcase
            end
            if (q_d.st != M_IDLE) begin
                {q_d.scl_oe_n, q_d.sda_oe_n} = pins(q_d.st, q_d.qtr, q_d.tx[BYTE_W]);
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            q_q          <= '0;
            q_q.scl_oe_n <= 1'b1;
            q_q.sda_oe_n <= 1'b1;
        end else begin
            q_q <= q_d;
        end
    end

    assign CMD_READY_OUT  = q_q.st == M_IDLE;
    assign RSP_VALID_OUT  = q_q.rsp_valid;
    assign RSP_DATA_OUT   = q_q.rsp_data;
    assign RSP_ACK_OUT    = q_q.rsp_ack;
    assign BUS.scl_out    = 1'b0;
    assign BUS.scl_oe_n   = q_q.scl_oe_n;
    assign BUS.sda_m_out  = 1'b0;
    assign BUS.sda_m_oe_n = q_q.sda_oe_n;
endmodule
`default_nettype wire

// ---- dv/rtctw_monitor.sv ----
// Wire-level checker for the two-wire link between both ends.
// Assumes CLK_IN runs far faster than SCL.
`timescale 1ns/1ps
`default_nettype none
module rtctw_monitor
    import rtctw_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_s_oe_n
);
    logic       scl_q, sda_q, busy_q, first_q, match_q, rd_q, nack_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    wire        rise  = scl && !scl_q;
    wire        start = scl && scl_q && sda_q && !sda;
    wire        stop  = scl && scl_q && !sda_q && sda;
    always_ff @(posedge CLK_IN) begin
        scl_q <= scl;
        sda_q <= sda;
        if (SRST_IN || start || stop) begin
            busy_q  <= start && !SRST_IN;
            first_q <= 1'b1;
            match_q <= 1'b0;
            rd_q    <= 1'b0;
            nack_q  <= 1'b0;
            cnt_q   <= 4'h0;
        end else if (rise) begin
            sh_q  <= {sh_q[6:0], sda};
            cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
            if (cnt_q == 4'h8) begin
                first_q <= 1'b0;
                nack_q  <= rd_q && !first_q && sda;
                if (first_q) begin
                    match_q <= (sh_q[7:1] == SLAVE_ADDR);
                    rd_q    <= sh_q[0];
                end
            end
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);
    property p_ack_addr; rise && cnt_q == 4'h8 && first_q && sh_q[7:1] == SLAVE_ADDR |-> !sda_s_oe_n; endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("address not acknowledged");
    property p_foreign; busy_q && !first_q && !match_q |-> sda_s_oe_n; endproperty
    a_foreign: assert property (p_foreign) else $error("foreign address driven");
    property p_ack_wr; rise && cnt_q == 4'h8 && !first_q && match_q && !rd_q |-> !sda_s_oe_n; endproperty
    a_ack_wr: assert property (p_ack_wr) else $error("write byte not acknowledged");
    property p_nack; nack_q |-> sda_s_oe_n; endproperty
    a_nack: assert property (p_nack) else $error("data driven after not-acknowledge");
    property p_rd_slot; rise && cnt_q == 4'h8 && !first_q && rd_q |-> sda_s_oe_n; endproperty
    a_rd_slot: assert property (p_rd_slot) else $error("slave drives master ack slot");
    property p_dev_edge; $changed(sda_s_oe_n) |-> !scl; endproperty
    a_dev_edge: assert property (p_dev_edge) else $error("slave data changed while SCL high");
    property p_scl_low; $fell(scl) |-> !scl [*8]; endproperty
    a_scl_low: assert property (p_scl_low) else $error("SCL low phase too short");
    property p_idle; !busy_q |-> sda_s_oe_n; endproperty
    a_idle: assert property (p_idle) else $error("slave drives an idle bus");
endmodule
`default_nettype wire

// ---- dv/rtctw_tb_top.sv ----
// Top bench: host and slave ends joined by one link, compared end to end.
// Assumes the package constants; QTR_CYC is shortened to keep the run short.
`timescale 1ns/1ps
`default_nettype none
module rtctw_tb_top;
    import rtctw_pkg::*;
    logic        clk = 1'b0, link_clk = 1'b0, srst = 1'b1, link_srst = 1'b1;
    logic        cmd_valid = 1'b0, cmd_last = 1'b0, ready, rsp_valid, rsp_ack, wr_stb;
    rtctw_cmd_t  cmd = CMD_START;
    logic [7:0]  cmd_data = 8'h00, rsp_data, wr_data, wdat;
    logic [5:0]  wr_addr;
    logic [63:0] time_in, t0;
    logic [8:0]  rq[$];
    logic [13:0] wq[$];
    int          seed = 32'h80E706A3, num_errors = 0, check_count = 0, cyc = 0;
    initial forever #2 clk = ~clk;
    initial #17 forever #62.5 link_clk = ~link_clk;
    rtctw_if bus_if();
    rtctw_host #(.QTR_CYC(300)) u_rtctw_host (.CLK_IN(clk), .SRST_IN(srst), .BUS(bus_if),
        .CMD_VALID_IN(cmd_valid), .CMD_READY_OUT(ready), .CMD_IN(cmd), .CMD_DATA_IN(cmd_data),
        .CMD_LAST_IN(cmd_last), .RSP_VALID_OUT(rsp_valid), .RSP_DATA_OUT(rsp_data),
        .RSP_ACK_OUT(rsp_ack));
    rtctw_dev u_rtctw_dev (.CLK_IN(clk), .SRST_IN(srst), .LINK_CLK_IN(link_clk),
        .LINK_SRST_IN(link_srst), .BUS(bus_if), .TIME_IN(time_in), .WR_STB_OUT(wr_stb),
        .WR_ADDR_OUT(wr_addr), .WR_DATA_OUT(wr_data));
    // Checker held off until the link end has left reset too
    rtctw_monitor u_rtctw_monitor (.CLK_IN(clk), .SRST_IN(srst || link_srst), .scl(bus_if.scl),
        .sda(bus_if.sda), .sda_s_oe_n(bus_if.sda_s_oe_n));
    ////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        if (num_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic send(input rtctw_cmd_t c, input logic [7:0] d, input logic l,
                        input logic [8:0] e);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd       <= c;
        cmd_data  <= d;
        cmd_last  <= l;
        if (c != CMD_STOP) rq.push_back(e);
        do @(posedge clk); while (ready !== 1'b1);
        cmd_valid <= 1'b0;
    endtask
    ////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (rsp_valid === 1'b1)
            check("rsp", {7'h00, rsp_ack, rsp_data}, rq.size() ? {7'h00, rq.pop_front()} : 16'hXXXX);
        if (wr_stb === 1'b1)
            check("wr", {2'h0, wr_addr, wr_data}, wq.size() ? {2'h0, wq.pop_front()} : 16'hXXXX);
        if (cyc == 95000) begin
            num_errors++;
            final_report();
        end
    end
    initial begin
        repeat (3) @(posedge link_clk);
        link_srst <= 1'b0;
    end
    initial begin
        t0 = {$random(seed), $random(seed)};
        time_in <= t0;
        wdat = 8'($random(seed));
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (8) @(posedge link_clk);
        send(CMD_START, {SLAVE_ADDR, DIR_WRITE}, 1'b0, {1'b1, SLAVE_ADDR, DIR_WRITE});
        send(CMD_WRITE, 8'h3F, 1'b0, {1'b1, 8'h3F});
        wq.push_back({6'h3F, wdat});
        send(CMD_WRITE, wdat, 1'b0, {1'b1, wdat});
        send(CMD_STOP, 8'h00, 1'b0, 9'h000);
        send(CMD_START, {SLAVE_ADDR, DIR_READ}, 1'b0, {1'b1, SLAVE_ADDR, DIR_READ});
        do @(posedge clk); while (ready !== 1'b1);
        time_in <= {$random(seed), $random(seed)};
        send(CMD_READ, 8'h00, 1'b0, {1'b1, t0[7:0]});
        send(CMD_READ, 8'h00, 1'b1, {1'b0, t0[15:8]});
        send(CMD_STOP, 8'h00, 1'b0, 9'h000);
        send(CMD_START, {SLAVE_ADDR ^ 7'h01, DIR_WRITE}, 1'b0, {1'b0, SLAVE_ADDR ^ 7'h01, DIR_WRITE});
        send(CMD_STOP, 8'h00, 1'b0, 9'h000);
        do @(posedge clk); while (ready !== 1'b1 || rq.size() != 0 || wq.size() != 0);
        final_report();
    end
endmodule
`default_nettype wire
